// ===== lrc_host_model.sv
// Purpose: host side model driving the register port
// Assumes: requests change on the falling edge
// Notes: stands for the serial master; one request per call
`timescale 1ns/100ps
module lrc_host_model (
   input wire logic clk,
   output lrc_pkg::lrc_req_t req
);
   import lrc_pkg::*;
   initial req = '0;
   // held from the falling edge until the next call replaces it
   task automatic acc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      req <= '{addr: a, write: w, read: r, wdata: d};
   endtask : acc
endmodule : lrc_host_model

// ===== lrc_pkg.sv
// Purpose: constants and carrier types for the linear regulator control registers
// Assumes: byte-wide register access from a serial control engine on the same clock
// Notes: reset values are the power-up defaults of every field
package lrc_pkg;

   // ----------------------------------------
   // register addresses
   // ----------------------------------------
   localparam logic [7:0] ADDR_REGULATOR_ENABLE = 8'h0b;
   localparam logic [7:0] ADDR_REG_ONE_TWO_SETTING = 8'h0c;
   localparam logic [7:0] ADDR_REG_THREE_SETTING = 8'h0d;
   localparam logic [7:0] ADDR_REG_FOUR_SETTING = 8'h0e;
   localparam logic [7:0] ADDR_REG_FIVE_SETTING = 8'h0f;
   localparam logic [7:0] ADDR_GPIO_THREE_CONFIG = 8'h1c;

   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int EN_REG_ONE_ON_BIT = 7;
   localparam int EN_REG_FIVE_ON_BIT = 3;
   localparam int EN_SUBSCRIBER_LEVEL_BIT = 2;
   localparam int EN_SUBSCRIBER_ON_BIT = 1;
   localparam int EN_BACKUP_ON_BIT = 0;
   localparam int ONE_TWO_ONE_DISCH_BIT = 7;
   localparam int ONE_TWO_ONE_SET_MSB = 6;
   localparam int ONE_TWO_ONE_SET_LSB = 4;
   localparam int ONE_TWO_TWO_DISCH_BIT = 3;
   localparam int ONE_TWO_TWO_SET_MSB = 2;
   localparam int ONE_TWO_TWO_SET_LSB = 0;
   localparam int STEP_DISCH_BIT = 7;
   localparam int STEP_CODE_MSB = 6;
   localparam int GPIO_REG_ZERO_ON_BIT = 5;
   localparam int NUM_SWITCHED = 5;

   // ----------------------------------------
   // power-up defaults
   // ----------------------------------------
   // regs one..five on, subscriber 1.8 V and off, backup on
   localparam logic [7:0] RST_REGULATOR_ENABLE = 8'hfd;
   // both discharge switches enabled, 100 = 2.85 V, 111 = 3.3 V
   localparam logic [7:0] RST_REG_ONE_TWO_SETTING = 8'hcf;
   // discharge enabled, step 1 = 1.25 V
   localparam logic [7:0] RST_REG_THREE_SETTING = 8'h81;
   // discharge enabled, step 60 = 2.754 V
   localparam logic [7:0] RST_REG_FOUR_SETTING = 8'hbc;
   // discharge enabled, step 62 = 2.805 V
   localparam logic [7:0] RST_REG_FIVE_SETTING = 8'hbe;
   // fixed regulator zero off, other pin bits cleared
   localparam logic [7:0] RST_GPIO_THREE_CONFIG = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // ----------------------------------------
   // carriers
   // ----------------------------------------
   typedef struct packed {
      logic [7:0] addr;
      logic write;
      logic read;
      logic [7:0] wdata;
   } lrc_req_t;

   typedef struct packed {
      logic [NUM_SWITCHED-1:0] regOn;          // [0] = regulator one
      logic [NUM_SWITCHED-1:0] regDischarge;   // discharge switch closed
      logic subscriberRegOn;
      logic subscriberRegLevel;                // 1 = 1.8 V, 0 = 3 V
      logic backupRegOn;
      logic regZeroOn;
      logic [2:0] regOneSet;
      logic [2:0] regTwoSet;
      logic [6:0] regThreeSet;
      logic [6:0] regFourSet;
      logic [6:0] regFiveSet;
   } lrc_ctrl_t;

endpackage : lrc_pkg

// ===== lrc_regs.sv
// Purpose: linear regulator control register bank with decoded regulator controls
// Assumes: requests come from the serial protocol engine on clk, one per cycle at most
// Notes: read data appears one edge after the access that causes it, controls two edges after
`timescale 1ns/100ps
module lrc_regs (
   input wire logic clk,
   input wire logic resetn,
   input wire lrc_pkg::lrc_req_t req,
   output lrc_pkg::lrc_ctrl_t ctrl,
   output logic [7:0] rdData,
   output logic rdValid
);
   import lrc_pkg::*;

   // ----------------------------------------
   // storage
   // ----------------------------------------
   logic [7:0] regulatorEnable;
   logic [7:0] regOneTwoSetting;
   logic [7:0] regThreeSetting;
   logic [7:0] regFourSetting;
   logic [7:0] regFiveSetting;
   logic [7:0] gpioThreeConfig;

   // ----------------------------------------
   // address decode
   // ----------------------------------------
   wire hitEnable = (req.addr == ADDR_REGULATOR_ENABLE);
   wire hitOneTwo = (req.addr == ADDR_REG_ONE_TWO_SETTING);
   wire hitThree = (req.addr == ADDR_REG_THREE_SETTING);
   wire hitFour = (req.addr == ADDR_REG_FOUR_SETTING);
   wire hitFive = (req.addr == ADDR_REG_FIVE_SETTING);
   wire hitGpio = (req.addr == ADDR_GPIO_THREE_CONFIG);
   wire anyHit = hitEnable | hitOneTwo | hitThree | hitFour | hitFive | hitGpio;

   // ----------------------------------------
   // read select
   // ----------------------------------------
   // hits are one-hot, so the read path is a plain or of masked bytes
   wire [7:0] readEnable = {8{hitEnable}} & regulatorEnable;
   wire [7:0] readOneTwo = {8{hitOneTwo}} & regOneTwoSetting;
   wire [7:0] readThree = {8{hitThree}} & regThreeSetting;
   wire [7:0] readFour = {8{hitFour}} & regFourSetting;
   wire [7:0] readFive = {8{hitFive}} & regFiveSetting;
   wire [7:0] readGpio = {8{hitGpio}} & gpioThreeConfig;
   // unmapped addresses read as zero and swallow writes
   wire [7:0] readUnmapped = {8{~anyHit}} & UNMAPPED_READ;
   wire [7:0] next_rdData = readEnable | readOneTwo | readThree | readFour |
      readFive | readGpio | readUnmapped;

   // ----------------------------------------
   // write strobes
   // ----------------------------------------
   // a write that hits no strobe is dropped without a trace
   wire wrEnable = req.write & hitEnable;
   wire wrOneTwo = req.write & hitOneTwo;
   wire wrThree = req.write & hitThree;
   wire wrFour = req.write & hitFour;
   wire wrFive = req.write & hitFive;
   wire wrGpio = req.write & hitGpio;

   // ----------------------------------------
   // register writes
   // ----------------------------------------
   // each byte holds until rewritten or reset
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         regulatorEnable <= RST_REGULATOR_ENABLE;
      end else if (wrEnable) begin
         regulatorEnable <= req.wdata;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         regOneTwoSetting <= RST_REG_ONE_TWO_SETTING;
      end else if (wrOneTwo) begin
         regOneTwoSetting <= req.wdata;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         regThreeSetting <= RST_REG_THREE_SETTING;
      end else if (wrThree) begin
         regThreeSetting <= req.wdata;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         regFourSetting <= RST_REG_FOUR_SETTING;
      end else if (wrFour) begin
         regFourSetting <= req.wdata;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         regFiveSetting <= RST_REG_FIVE_SETTING;
      end else if (wrFive) begin
         regFiveSetting <= req.wdata;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         gpioThreeConfig <= RST_GPIO_THREE_CONFIG;
      end else if (wrGpio) begin
         gpioThreeConfig <= req.wdata;
      end
   end

   // ----------------------------------------
   // read port
   // ----------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rdValid <= 1'b0;
      end else begin
         rdValid <= req.read;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rdData <= UNMAPPED_READ;
      end else if (req.read) begin
         rdData <= next_rdData;
      end
   end

   // ----------------------------------------
   // field decode
   // ----------------------------------------
   wire [NUM_SWITCHED-1:0] onBits;
   wire [NUM_SWITCHED-1:0] dischEnable;
   wire lrc_ctrl_t next_ctrl;

   assign dischEnable = {regFiveSetting[STEP_DISCH_BIT],
                         regFourSetting[STEP_DISCH_BIT],
                         regThreeSetting[STEP_DISCH_BIT],
                         regOneTwoSetting[ONE_TWO_TWO_DISCH_BIT],
                         regOneTwoSetting[ONE_TWO_ONE_DISCH_BIT]};

   genvar i;
   generate
      for (i = 0; i < NUM_SWITCHED; i++) begin : g_sw
         // bit 7 is regulator one, so index runs downward in the register
         assign onBits[i] = regulatorEnable[EN_REG_ONE_ON_BIT - i];
         // switch closes only while the regulator is off, never fighting the pass device
         assign next_ctrl.regDischarge[i] = dischEnable[i] & ~onBits[i];
      end
   endgenerate

   assign next_ctrl.regOn = onBits;
   assign next_ctrl.subscriberRegOn = regulatorEnable[EN_SUBSCRIBER_ON_BIT];
   assign next_ctrl.backupRegOn = regulatorEnable[EN_BACKUP_ON_BIT];
   assign next_ctrl.subscriberRegLevel = regulatorEnable[EN_SUBSCRIBER_LEVEL_BIT];
   assign next_ctrl.regZeroOn = gpioThreeConfig[GPIO_REG_ZERO_ON_BIT];
   assign next_ctrl.regOneSet =
      regOneTwoSetting[ONE_TWO_ONE_SET_MSB:ONE_TWO_ONE_SET_LSB];
   assign next_ctrl.regTwoSet =
      regOneTwoSetting[ONE_TWO_TWO_SET_MSB:ONE_TWO_TWO_SET_LSB];
   assign next_ctrl.regThreeSet = regThreeSetting[STEP_CODE_MSB:0];
   assign next_ctrl.regFourSet = regFourSetting[STEP_CODE_MSB:0];
   assign next_ctrl.regFiveSet = regFiveSetting[STEP_CODE_MSB:0];

   // ----------------------------------------
   // registered controls
   // ----------------------------------------
   // one cycle of lag keeps analog controls glitch free
   // controls sit at zero in reset, so every supply is off until release
   logic [NUM_SWITCHED-1:0] regulatorOn;
   logic [NUM_SWITCHED-1:0] switchClosed;
   logic subscriberOn;
   logic subscriberLevel;
   logic backupOn;
   logic zeroOn;
   logic [2:0] oneSet;
   logic [2:0] twoSet;
   logic [6:0] threeSet;
   logic [6:0] fourSet;
   logic [6:0] fiveSet;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         regulatorOn <= '0;
      end else begin
         regulatorOn <= next_ctrl.regOn;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         switchClosed <= '0;
      end else begin
         switchClosed <= next_ctrl.regDischarge;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         subscriberOn <= 1'b0;
      end else begin
         subscriberOn <= next_ctrl.subscriberRegOn;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         subscriberLevel <= 1'b0;
      end else begin
         subscriberLevel <= next_ctrl.subscriberRegLevel;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         backupOn <= 1'b0;
      end else begin
         backupOn <= next_ctrl.backupRegOn;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         zeroOn <= 1'b0;
      end else begin
         zeroOn <= next_ctrl.regZeroOn;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         oneSet <= '0;
      end else begin
         oneSet <= next_ctrl.regOneSet;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         twoSet <= '0;
      end else begin
         twoSet <= next_ctrl.regTwoSet;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         threeSet <= '0;
      end else begin
         threeSet <= next_ctrl.regThreeSet;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         fourSet <= '0;
      end else begin
         fourSet <= next_ctrl.regFourSet;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         fiveSet <= '0;
      end else begin
         fiveSet <= next_ctrl.regFiveSet;
      end
   end

   // ----------------------------------------
   // control outputs
   // ----------------------------------------
   assign ctrl = '{
      regOn: regulatorOn,
      regDischarge: switchClosed,
      subscriberRegOn: subscriberOn,
      subscriberRegLevel: subscriberLevel,
      backupRegOn: backupOn,
      regZeroOn: zeroOn,
      regOneSet: oneSet,
      regTwoSet: twoSet,
      regThreeSet: threeSet,
      regFourSet: fourSet,
      regFiveSet: fiveSet
   };

endmodule : lrc_regs

// ===== lrc_regs_monitor.sv
// Purpose: port checker for the regulator register bank
// Assumes: one clock, resetn asynchronous and active low
// Notes: bound to every lrc_regs instance
`timescale 1ns/100ps
module lrc_regs_monitor (
   input wire logic clk,
   input wire logic resetn,
   input wire lrc_pkg::lrc_req_t req,
   input wire lrc_pkg::lrc_ctrl_t ctrl,
   input wire logic [7:0] rdData,
   input wire logic rdValid
);
   import lrc_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   read_answer_a: assert property (req.read |=> rdValid)
      else $error("read not answered");
   quiet_read_a: assert property (!req.read |=> !rdValid && $stable(rdData))
      else $error("read data moved");
   enable_decode_a: assert property (req.write && req.addr == ADDR_REGULATOR_ENABLE
      |=> ##1 {ctrl.regOn[0], ctrl.regOn[1], ctrl.regOn[2], ctrl.regOn[3], ctrl.regOn[4],
      ctrl.subscriberRegLevel, ctrl.subscriberRegOn, ctrl.backupRegOn} == $past(req.wdata, 2))
      else $error("enable decode wrong");
   one_two_a: assert property (req.write && req.addr == ADDR_REG_ONE_TWO_SETTING |=> ##1
      {ctrl.regOneSet, ctrl.regTwoSet} == {$past(req.wdata[6:4], 2), $past(req.wdata[2:0], 2)})
      else $error("voltage codes wrong");
   four_code_a: assert property (req.write && req.addr == ADDR_REG_FOUR_SETTING |=> ##1
      ctrl.regFourSet == $past(req.wdata[6:0], 2)) else $error("step code wrong");
   zero_on_a: assert property (req.write && req.addr == ADDR_GPIO_THREE_CONFIG |=> ##1
      ctrl.regZeroOn == $past(req.wdata[5], 2)) else $error("regulator zero wrong");
   discharge_off_a: assert property ((ctrl.regDischarge & ctrl.regOn) == 5'h00)
      else $error("discharge while on");
   one_disch_a: assert property (req.write && req.addr == ADDR_REG_ONE_TWO_SETTING
      |=> ##1 ctrl.regDischarge[1:0] ==
      ({$past(req.wdata[3], 2), $past(req.wdata[7], 2)} & ~ctrl.regOn[1:0]))
      else $error("discharge switch wrong");
   read_back_a: assert property (req.write && req.addr inside {[8'h0b:8'h0f]} ##1
      req.read && !req.write && $stable(req.addr) |=> rdData == $past(req.wdata, 2))
      else $error("read back differs");
   cover property (req.write ##1 req.read);
   cover property (rdValid && rdData == 8'h00);
   cover property (ctrl.regDischarge == 5'h1f);
endmodule : lrc_regs_monitor
bind lrc_regs lrc_regs_monitor mon_u (.clk(clk), .resetn(resetn), .req(req), .ctrl(ctrl),
   .rdData(rdData), .rdValid(rdValid));

// ===== lrc_regs_test.sv
// Purpose: self-checking bench for the regulator register bank
// Assumes: 50 MHz clock, host model on the register port
// Notes: random writes with read-back, decode checked from a shadow copy
`timescale 1ns/100ps
module lrc_regs_test;
   import lrc_pkg::*;
   logic clk;
   logic resetn = 1'b0;
   lrc_req_t req;
   lrc_ctrl_t ctrl;
   logic [7:0] rdData;
   logic rdValid;
   int errors = 0;
   int tests_run = 0;
   int cycles = 0;
   int seed = 12312;
   logic [7:0] sh [6];
   logic [7:0] addrs [6] = '{8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h1c};
   lrc_host_model host_u (.clk(clk), .req(req));
   lrc_regs dut_u (.clk(clk), .resetn(resetn), .req(req), .ctrl(ctrl), .rdData(rdData),
      .rdValid(rdValid));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic conclude();
      $display("errors %0d, checks %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : conclude
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      host_u.acc(1'b0, 1'b1, a, 8'($random(seed)));
      host_u.acc(1'b0, 1'b0, ~a, 8'($random(seed)));
      chk(rdValid, 1'b1);
      chk(rdData, e);
   endtask : rd_chk
   function automatic lrc_ctrl_t exp_ctrl();
      lrc_ctrl_t c;
      c.regOn = {sh[0][3], sh[0][4], sh[0][5], sh[0][6], sh[0][7]};
      // switch closed only while enabled and off
      c.regDischarge = {sh[4][7], sh[3][7], sh[2][7], sh[1][3], sh[1][7]} & ~c.regOn;
      c.subscriberRegOn = sh[0][1];
      c.subscriberRegLevel = sh[0][2];
      c.backupRegOn = sh[0][0];
      c.regZeroOn = sh[5][5];
      c.regOneSet = sh[1][6:4];
      c.regTwoSet = sh[1][2:0];
      c.regThreeSet = sh[2][6:0];
      c.regFourSet = sh[3][6:0];
      c.regFiveSet = sh[4][6:0];
      return c;
   endfunction : exp_ctrl
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         errors++;
         conclude();
      end
   end
   initial begin
      int k;
      logic [7:0] d;
      for (int rep = 0; rep < 2; rep++) begin
         resetn = 1'b0;
         sh = '{8'hfd, 8'hcf, 8'h81, 8'hbc, 8'hbe, 8'h00};
         repeat (12) @(negedge clk);
         resetn = 1'b1;
         for (int i = 0; i < 6; i++) rd_chk(addrs[i], sh[i]);
         chk(ctrl, exp_ctrl());
         host_u.acc(1'b1, 1'b0, 8'h10, 8'hff);
         rd_chk(8'h10, 8'h00);
         host_u.acc(1'b1, 1'b1, addrs[0], ~sh[0]);
         host_u.acc(1'b0, 1'b0, 8'h00, 8'h00);
         chk(rdData, sh[0]);
         rd_chk(addrs[0], ~sh[0]);
         sh[0] = ~sh[0];
         for (int n = 0; n < 200; n++) begin
            k = {$random(seed)} % 6;
            d = (n < 12) ? {8{n[0]}} : 8'($random(seed));
            host_u.acc(1'b1, 1'b0, addrs[k], d);
            sh[k] = d;
            rd_chk(addrs[k], d);
            chk(ctrl, exp_ctrl());
         end
      end
      conclude();
   end
endmodule : lrc_regs_test
